// ==== src/vsb_pkg.sv ====
// Purpose: shared constants, types and helpers for the vector issue scoreboard
// Assumes: all figures are clock periods of the single processor clock
// Notes: reservation counters are CNT_W bits wide, enough for latency plus 64 + 2
package vsb_pkg;

    // ==========================================================
    // widths and sizes
    localparam int CNT_W = 8;
    localparam int VL_W = 7;
    localparam int NUM_VREG = 8;
    localparam int NUM_UNIT = 7;

    typedef logic [CNT_W-1:0] vsb_cnt_t;
    typedef logic [VL_W-1:0] vsb_vl_t;

    // ==========================================================
    // enumerations
    typedef enum logic [2:0] {
        VSB_U_LOGIC = 3'h0,
        VSB_U_SHIFT = 3'h1,
        VSB_U_IADD = 3'h2,
        VSB_U_FADD = 3'h3,
        VSB_U_FMUL = 3'h4,
        VSB_U_RECIP = 3'h5,
        VSB_U_MEM = 3'h6
    } vsb_unit_t;

    typedef enum logic [1:0] {
        VSB_K_VECTOR = 2'h0,
        VSB_K_SCALAR = 2'h1,
        VSB_K_BRANCH = 2'h2,
        VSB_K_BLKCOPY = 2'h3
    } vsb_kind_t;

    typedef enum logic [1:0] {
        VSB_BR_FALL = 2'h0,
        VSB_BR_TAKEN = 2'h1,
        VSB_BR_OUT = 2'h2
    } vsb_br_t;

    // gray along run -> gap -> run and run -> hold -> run
    typedef enum logic [1:0] {
        VSB_ST_RUN = 2'h0,
        VSB_ST_GAP = 2'h1,
        VSB_ST_HOLD = 2'h2
    } vsb_state_t;

    // ==========================================================
    // unit latencies
    localparam vsb_cnt_t LAT_LOGIC = 8'h02;
    localparam vsb_cnt_t LAT_SHIFT = 8'h03;
    localparam vsb_cnt_t LAT_IADD = 8'h03;
    localparam vsb_cnt_t LAT_FADD = 8'h06;
    localparam vsb_cnt_t LAT_FMUL = 8'h07;
    localparam vsb_cnt_t LAT_RECIP = 8'h0E;
    localparam vsb_cnt_t LAT_MEM = 8'h06;

    // ==========================================================
    // reservation lengths and issue gaps
    localparam vsb_cnt_t UNIT_PLUS = 8'h02;
    localparam vsb_cnt_t MEM_PLUS = 8'h04;
    localparam vsb_cnt_t SHARE_PLUS = 8'h04;
    localparam vsb_cnt_t SHARE_EXT = SHARE_PLUS - UNIT_PLUS;
    localparam vsb_cnt_t RES_PLUS = 8'h02;
    localparam vsb_cnt_t RES_SHORT_PLUS = 8'h07;
    localparam vsb_cnt_t CHAIN_PLUS = 8'h02;
    localparam vsb_cnt_t OPND_PLUS = 8'h01;
    localparam vsb_cnt_t OPND_SHORT = 8'h06;
    localparam vsb_cnt_t VSTORE_PLUS = 8'h05;
    localparam vsb_cnt_t BLK_LOAD_PLUS = 8'h0D;
    localparam vsb_cnt_t BLK_STORE_PLUS = 8'h05;
    localparam vsb_cnt_t BR_FALL_TIME = 8'h02;
    localparam vsb_cnt_t BR_TAKEN_TIME = 8'h05;
    localparam vsb_cnt_t BR_OUT_TIME = 8'h0D;
    localparam vsb_cnt_t GAP_CYC = 8'h01;
    localparam vsb_cnt_t CNT_RST = 8'h00;
    localparam vsb_vl_t SHORT_VL = 7'h05;
    localparam vsb_vl_t MAX_VL = 7'h40;

    function automatic vsb_cnt_t vsb_unit_lat(input vsb_unit_t u);
        unique case (u)
            VSB_U_LOGIC: vsb_unit_lat = LAT_LOGIC;
            VSB_U_SHIFT: vsb_unit_lat = LAT_SHIFT;
            VSB_U_IADD: vsb_unit_lat = LAT_IADD;
            VSB_U_FADD: vsb_unit_lat = LAT_FADD;
            VSB_U_FMUL: vsb_unit_lat = LAT_FMUL;
            VSB_U_RECIP: vsb_unit_lat = LAT_RECIP;
            VSB_U_MEM: vsb_unit_lat = LAT_MEM;
            default: vsb_unit_lat = LAT_LOGIC;
        endcase
    endfunction

endpackage

// ==== src/vsb_dur_if.sv ====
// Purpose: reservation lengths carried from the decoder to the scoreboard core
// Assumes: all values are valid in the cycle the request is presented
// Notes: zero in hold means no issue gap follows
`timescale 1ns/1ps
interface vsb_dur_if;
    import vsb_pkg::*;
    vsb_cnt_t unit_cnt;
    vsb_cnt_t res_cnt;
    vsb_cnt_t chain_cnt;
    vsb_cnt_t opj_cnt;
    vsb_cnt_t opk_cnt;
    vsb_cnt_t hold_cnt;
    modport drv (output unit_cnt, res_cnt, chain_cnt, opj_cnt, opk_cnt, hold_cnt);
    modport use_side (input unit_cnt, res_cnt, chain_cnt, opj_cnt, opk_cnt, hold_cnt);
endinterface

// ==== src/vsb_rsv_cnt.sv ====
// Purpose: one reservation down-counter
// Assumes: load and extend are never asked in the same cycle
// Notes: extension is granted once per load
`timescale 1ns/1ps
module vsb_rsv_cnt import vsb_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // control
    input wire logic i_load,
    input wire vsb_cnt_t i_load_val,
    input wire logic i_ext,
    // state
    output logic o_busy,
    output logic o_last
);
    vsb_cnt_t cnt_r, cnt_nxt;
    logic ext_done_r, ext_done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        ext_done_nxt = ext_done_r;
        if (i_load) begin
            cnt_nxt = i_load_val;
            ext_done_nxt = 1'b0;
        end else if (cnt_r != CNT_RST) begin
            cnt_nxt = cnt_r - 8'h01;
            if (i_ext && !ext_done_r) begin
                cnt_nxt = cnt_r - 8'h01 + SHARE_EXT;
                ext_done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r <= CNT_RST;
            ext_done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ext_done_r <= ext_done_nxt;
        end
    end

    assign o_busy = (cnt_r != CNT_RST);
    assign o_last = (cnt_r == 8'h01);
endmodule

// ==== src/vsb_issue_decode.sv ====
// Purpose: turn one presented request into its reservation and gap lengths
// Assumes: element count above 64 never reaches here in correct code
// Notes: purely combinational
`timescale 1ns/1ps
module vsb_issue_decode import vsb_pkg::*; (
    // request
    input wire vsb_kind_t i_kind,
    input wire vsb_unit_t i_unit,
    input wire logic i_vstore,
    input wire logic i_two_parcel,
    input wire vsb_vl_t i_element_count_setting,
    input wire logic i_blk_load,
    input wire logic [5:0] i_block_copy_count_field,
    input wire vsb_br_t i_br_outcome,
    // lengths
    vsb_dur_if.drv dur
);
    vsb_vl_t vl;
    vsb_cnt_t vlc;
    vsb_cnt_t lat;
    vsb_cnt_t jk;
    vsb_cnt_t gap;
    logic short_v;

    always_comb begin
        // a longer count is cut to one segment; more would overrun the registers
        vl = (i_element_count_setting > MAX_VL) ? MAX_VL : i_element_count_setting;
        vlc = vsb_cnt_t'(vl);
        lat = vsb_unit_lat(i_unit);
        jk = vsb_cnt_t'(i_block_copy_count_field);
        short_v = (vl < SHORT_VL);
        dur.unit_cnt = vlc + ((i_unit == VSB_U_MEM) ? MEM_PLUS : UNIT_PLUS);
        dur.res_cnt = lat + (short_v ? RES_SHORT_PLUS : (vlc + RES_PLUS));
        dur.chain_cnt = lat + CHAIN_PLUS;
        dur.opk_cnt = short_v ? OPND_SHORT : (vlc + OPND_PLUS);
        dur.opj_cnt = i_vstore ? (vlc + VSTORE_PLUS) : dur.opk_cnt;
        gap = CNT_RST;
        unique case (i_kind)
            VSB_K_BLKCOPY: gap = jk + (i_blk_load ? BLK_LOAD_PLUS : BLK_STORE_PLUS);
            VSB_K_BRANCH: begin
                unique case (i_br_outcome)
                    VSB_BR_FALL: gap = BR_FALL_TIME - 8'h01;
                    VSB_BR_TAKEN: gap = BR_TAKEN_TIME - 8'h01;
                    VSB_BR_OUT: gap = BR_OUT_TIME - 8'h01;
                    default: gap = BR_OUT_TIME - 8'h01;
                endcase
            end
            VSB_K_VECTOR: gap = CNT_RST;
            VSB_K_SCALAR: gap = CNT_RST;
        endcase
        dur.hold_cnt = (i_two_parcel && gap < GAP_CYC) ? GAP_CYC : gap;
    end
endmodule

// ==== src/vsb_scoreboard.sv ====
// Purpose: vector issue control and reservation scoreboard
// Assumes: request fields are steady while i_req_valid is high
// Notes: o_issue is combinational; the issue stage treats it as taken
`timescale 1ns/1ps
module vsb_scoreboard import vsb_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // request from the issue stage
    input wire logic i_req_valid,
    input wire vsb_kind_t i_req_kind,
    input wire vsb_unit_t i_req_unit,
    input wire logic i_req_unit_en,
    input wire logic i_req_vstore,
    input wire logic i_req_two_parcel,
    input wire logic i_req_res_en,
    input wire logic [2:0] i_req_res_vreg,
    input wire logic i_req_opj_en,
    input wire logic [2:0] i_req_opj_vreg,
    input wire logic i_req_opk_en,
    input wire logic [2:0] i_req_opk_vreg,
    // request details
    input wire vsb_vl_t i_element_count_setting,
    input wire logic i_blk_load,
    input wire logic [5:0] i_block_copy_count_field,
    input wire vsb_br_t i_br_outcome,
    input wire logic i_br_uses_scalar,
    // busy levels from the scalar side
    input wire logic i_branch_address_test_reg_busy,
    input wire logic i_branch_scalar_test_reg_busy,
    // issue answer
    output logic o_issue,
    // scoreboard state
    output logic [NUM_UNIT-1:0] o_unit_busy,
    output logic [NUM_VREG-1:0] o_vreg_busy,
    output logic [NUM_VREG-1:0] o_chain_slot,
    output logic o_mem_quiet,
    output logic o_issue_hold
);
    // ==========================================================
    // request decode
    vsb_dur_if dur ();

    vsb_issue_decode u_dec (
        .i_kind(i_req_kind),
        .i_unit(i_req_unit),
        .i_vstore(i_req_vstore),
        .i_two_parcel(i_req_two_parcel),
        .i_element_count_setting(i_element_count_setting),
        .i_blk_load(i_blk_load),
        .i_block_copy_count_field(i_block_copy_count_field),
        .i_br_outcome(i_br_outcome),
        .dur(dur.drv)
    );

    // ==========================================================
    // reservation counters
    logic [NUM_UNIT-1:0] unit_load, unit_ext, unit_busy;
    logic [NUM_VREG-1:0] res_load, res_busy;
    logic [NUM_VREG-1:0] chain_busy, chain_last;
    logic [NUM_VREG-1:0] opnd_load, opnd_busy;
    vsb_cnt_t opnd_val [NUM_VREG];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNIT; gi++) begin : g_unit
            vsb_rsv_cnt u_cnt (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_load(unit_load[gi]),
                .i_load_val(dur.unit_cnt),
                .i_ext(unit_ext[gi]),
                .o_busy(unit_busy[gi]),
                .o_last()
            );
        end
        for (gi = 0; gi < NUM_VREG; gi++) begin : g_vreg
            vsb_rsv_cnt u_res (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_load(res_load[gi]),
                .i_load_val(dur.res_cnt),
                .i_ext(1'b0),
                .o_busy(res_busy[gi]),
                .o_last()
            );
            vsb_rsv_cnt u_chain (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_load(res_load[gi]),
                .i_load_val(dur.chain_cnt),
                .i_ext(1'b0),
                .o_busy(chain_busy[gi]),
                .o_last(chain_last[gi])
            );
            vsb_rsv_cnt u_opnd (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_load(opnd_load[gi]),
                .i_load_val(opnd_val[gi]),
                .i_ext(1'b0),
                .o_busy(opnd_busy[gi]),
                .o_last()
            );
        end
    endgenerate

    // ==========================================================
    // issue gap state
    vsb_state_t state_r, state_nxt;
    vsb_cnt_t hold_r, hold_nxt;
    logic a_busy_d_r, a_busy_d_nxt;
    logic s_busy_d_r, s_busy_d_nxt;

    // ==========================================================
    // issue conditions
    logic mem_quiet;
    logic unit_ok, res_ok, opj_ok, opk_ok, br_ok, may_issue, issue;
    logic shared_unit;

    always_comb begin
        mem_quiet = !unit_busy[VSB_U_MEM];
        unit_ok = !unit_busy[i_req_unit];
        // writing a register still being read would corrupt the reader
        res_ok = !i_req_res_en || (!res_busy[i_req_res_vreg] && !opnd_busy[i_req_res_vreg]);
        opj_ok = !i_req_opj_en || !res_busy[i_req_opj_vreg]
            || (chain_last[i_req_opj_vreg] && chain_busy[i_req_opj_vreg]);
        opk_ok = !i_req_opk_en || !res_busy[i_req_opk_vreg]
            || (chain_last[i_req_opk_vreg] && chain_busy[i_req_opk_vreg]);
        if (i_br_uses_scalar) begin
            br_ok = !i_branch_scalar_test_reg_busy && !s_busy_d_r;
        end else begin
            br_ok = !i_branch_address_test_reg_busy && !a_busy_d_r;
        end
        shared_unit = (i_req_unit == VSB_U_FADD) || (i_req_unit == VSB_U_FMUL)
            || (i_req_unit == VSB_U_RECIP) || (i_req_unit == VSB_U_MEM);
        may_issue = 1'b0;
        unique case (i_req_kind)
            VSB_K_VECTOR: may_issue = unit_ok && res_ok && opj_ok && opk_ok;
            VSB_K_SCALAR: may_issue = !i_req_unit_en || !shared_unit || unit_ok;
            VSB_K_BRANCH: may_issue = br_ok;
            VSB_K_BLKCOPY: may_issue = mem_quiet;
        endcase
        issue = i_req_valid && may_issue && (state_r == VSB_ST_RUN);
    end

    // ==========================================================
    // reservation loads
    always_comb begin
        unit_load = '0;
        unit_ext = '0;
        res_load = '0;
        opnd_load = '0;
        for (int i = 0; i < NUM_VREG; i++) begin
            opnd_val[i] = dur.opk_cnt;
        end
        if (issue && i_req_kind == VSB_K_VECTOR) begin
            unit_load[i_req_unit] = 1'b1;
            if (i_req_res_en) begin
                res_load[i_req_res_vreg] = 1'b1;
            end
            // scalar operands carry no enable here and are never reserved
            if (i_req_opk_en) begin
                opnd_load[i_req_opk_vreg] = 1'b1;
            end
            if (i_req_opj_en) begin
                opnd_load[i_req_opj_vreg] = 1'b1;
                opnd_val[i_req_opj_vreg] = dur.opj_cnt;
            end
        end
        if (i_req_valid && i_req_kind == VSB_K_SCALAR && i_req_unit_en && shared_unit) begin
            unit_ext[i_req_unit] = 1'b1;
        end
    end

    // ==========================================================
    // issue gap machine
    always_comb begin
        state_nxt = state_r;
        hold_nxt = hold_r;
        a_busy_d_nxt = i_branch_address_test_reg_busy;
        s_busy_d_nxt = i_branch_scalar_test_reg_busy;
        unique case (state_r)
            VSB_ST_RUN: begin
                if (issue && dur.hold_cnt == GAP_CYC) begin
                    state_nxt = VSB_ST_GAP;
                end else if (issue && dur.hold_cnt > GAP_CYC) begin
                    state_nxt = VSB_ST_HOLD;
                    hold_nxt = dur.hold_cnt;
                end
            end
            VSB_ST_GAP: begin
                state_nxt = VSB_ST_RUN;
            end
            VSB_ST_HOLD: begin
                hold_nxt = hold_r - 8'h01;
                if (hold_r == 8'h01) begin
                    state_nxt = VSB_ST_RUN;
                    hold_nxt = CNT_RST;
                end
            end
            default: begin
                state_nxt = VSB_ST_RUN;
                hold_nxt = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= VSB_ST_RUN;
            hold_r <= CNT_RST;
            a_busy_d_r <= 1'b1;
            s_busy_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            a_busy_d_r <= a_busy_d_nxt;
            s_busy_d_r <= s_busy_d_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign o_issue = issue;
    assign o_unit_busy = unit_busy;
    assign o_vreg_busy = res_busy | opnd_busy;
    assign o_chain_slot = chain_busy & chain_last;
    assign o_mem_quiet = mem_quiet;
    assign o_issue_hold = (state_r != VSB_ST_RUN);
endmodule

// ==== dv/vsb_scoreboard_assertions.sv ====
// Purpose: port-level checks on the vector issue scoreboard
// Assumes: single clock domain, asynchronous reset high
// Notes: figures tied to the element counts the bench really uses
`timescale 1ns/1ps
module vsb_scoreboard_assertions import vsb_pkg::*; (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire vsb_kind_t i_req_kind,
    input wire vsb_unit_t i_req_unit,
    input wire logic i_req_two_parcel,
    input wire logic i_req_res_en,
    input wire logic [2:0] i_req_res_vreg,
    input wire vsb_vl_t i_element_count_setting,
    input wire logic i_br_uses_scalar,
    input wire logic i_branch_address_test_reg_busy,
    input wire logic o_issue,
    input wire logic [NUM_UNIT-1:0] o_unit_busy,
    input wire logic [NUM_VREG-1:0] o_vreg_busy,
    input wire logic [NUM_VREG-1:0] o_chain_slot,
    input wire logic o_mem_quiet,
    input wire logic o_issue_hold
);
    // ==========================================================
    // checks
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic vec_issue;
    assign vec_issue = o_issue && i_req_kind == VSB_K_VECTOR;

    pair_gap_a: assert property (
        o_issue && i_req_two_parcel |=> o_issue_hold && !o_issue)
        else $error("issue right after a two-parcel instruction");
    hold_blocks_a: assert property (
        o_issue_hold |-> !o_issue)
        else $error("issue during a gap");
    unit_free_a: assert property (
        i_req_valid && i_req_kind == VSB_K_VECTOR && o_unit_busy[i_req_unit] |-> !o_issue)
        else $error("vector issued onto a busy unit");
    copy_quiet_a: assert property (
        i_req_valid && i_req_kind == VSB_K_BLKCOPY && !o_mem_quiet |-> !o_issue)
        else $error("block copy issued while memory busy");
    unit_span_a: assert property (
        vec_issue && i_req_unit == VSB_U_LOGIC && i_element_count_setting == 7'h08
        |=> o_unit_busy[0] [*8] ##1 o_unit_busy[0] [*2] ##1 !o_unit_busy[0])
        else $error("logical unit reservation length wrong");
    chain_time_a: assert property (
        vec_issue && i_req_unit == VSB_U_LOGIC && i_req_res_en && i_req_res_vreg == 3'h1
        |-> ##4 o_chain_slot[1] ##1 !o_chain_slot[1])
        else $error("chain slot at the wrong period");
    branch_wait_a: assert property (
        i_req_valid && i_req_kind == VSB_K_BRANCH && !i_br_uses_scalar
        && ($past(i_branch_address_test_reg_busy) || i_branch_address_test_reg_busy)
        |-> !o_issue)
        else $error("branch issued before its test register was free");
    short_result_a: assert property (
        vec_issue && i_req_unit == VSB_U_FMUL && i_element_count_setting == 7'h03
        && i_req_res_en && i_req_res_vreg == 3'h2
        |=> o_vreg_busy[2] [*8] ##1 o_vreg_busy[2] [*6] ##1 !o_vreg_busy[2])
        else $error("short result reservation length wrong");
    mem_span_a: assert property (
        vec_issue && i_req_unit == VSB_U_MEM && i_element_count_setting == 7'h02
        |=> !o_mem_quiet [*6] ##1 o_mem_quiet)
        else $error("memory reservation length wrong");
endmodule

bind vsb_scoreboard vsb_scoreboard_assertions vsb_scoreboard_assertions_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .i_req_kind(i_req_kind), .i_req_unit(i_req_unit), .i_req_two_parcel(i_req_two_parcel),
    .i_req_res_en(i_req_res_en), .i_req_res_vreg(i_req_res_vreg),
    .i_element_count_setting(i_element_count_setting), .i_br_uses_scalar(i_br_uses_scalar),
    .i_branch_address_test_reg_busy(i_branch_address_test_reg_busy), .o_issue(o_issue),
    .o_unit_busy(o_unit_busy), .o_vreg_busy(o_vreg_busy), .o_chain_slot(o_chain_slot),
    .o_mem_quiet(o_mem_quiet), .o_issue_hold(o_issue_hold));

// ==== dv/vsb_scalar_side.sv ====
// Purpose: scalar side model driving the branch test register busy levels
// Assumes: a load names one register and its busy length
// Notes: one register busy at a time, enough for the branch cases
`timescale 1ns/1ps
module vsb_scalar_side (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // control
    input wire logic i_load,
    input wire logic i_sel,
    input wire logic [7:0] i_len,
    // busy levels
    output logic o_addr_busy,
    output logic o_scal_busy
);
    // ==========================================================
    // busy counter
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic sel_r;
    logic sel_nxt;
    always_comb begin
        cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
        sel_nxt = sel_r;
        if (i_load) begin
            cnt_nxt = i_len;
            sel_nxt = i_sel;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r <= 8'h00;
            sel_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sel_r <= sel_nxt;
        end
    end
    assign o_addr_busy = (cnt_r != 8'h00) && !sel_r;
    assign o_scal_busy = (cnt_r != 8'h00) && sel_r;
endmodule

// ==== dv/vsb_scoreboard_test.sv ====
// Purpose: self-checking bench for the vector issue scoreboard
// Assumes: one request at a time, held until it issues
// Notes: issue is read at the falling edge, once o_issue has settled
`timescale 1ns/1ps
module vsb_scoreboard_test import vsb_pkg::*;;
    typedef struct packed {
        vsb_kind_t kind;
        vsb_unit_t unit;
        logic unit_en;
        logic vstore;
        logic pair;
        logic [3:0] res;
        logic [3:0] opj;
        logic [3:0] opk;
        vsb_vl_t vl;
        logic blk_load;
        logic [5:0] cnt;
        vsb_br_t br;
        logic uses_s;
    } vsb_req_t;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic valid, ld, sel, addr_busy, scal_busy, o_issue, mem_quiet, hold;
    logic [7:0] len, vbusy, chain;
    logic [6:0] ubusy;
    vsb_req_t rq;
    int cyc, n_fail, checks;

    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;

    vsb_scoreboard vsb_scoreboard_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_req_valid(valid), .i_req_kind(rq.kind), .i_req_unit(rq.unit),
        .i_req_unit_en(rq.unit_en), .i_req_vstore(rq.vstore), .i_req_two_parcel(rq.pair),
        .i_req_res_en(rq.res[3]), .i_req_res_vreg(rq.res[2:0]),
        .i_req_opj_en(rq.opj[3]), .i_req_opj_vreg(rq.opj[2:0]),
        .i_req_opk_en(rq.opk[3]), .i_req_opk_vreg(rq.opk[2:0]),
        .i_element_count_setting(rq.vl), .i_blk_load(rq.blk_load),
        .i_block_copy_count_field(rq.cnt), .i_br_outcome(rq.br), .i_br_uses_scalar(rq.uses_s),
        .i_branch_address_test_reg_busy(addr_busy), .i_branch_scalar_test_reg_busy(scal_busy),
        .o_issue(o_issue), .o_unit_busy(ubusy), .o_vreg_busy(vbusy), .o_chain_slot(chain),
        .o_mem_quiet(mem_quiet), .o_issue_hold(hold));
    vsb_scalar_side vsb_scalar_side_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld),
        .i_sel(sel), .i_len(len), .o_addr_busy(addr_busy), .o_scal_busy(scal_busy));

    // ==========================================================
    // helpers
    function automatic vsb_req_t vec(vsb_unit_t u, vsb_vl_t n, logic [3:0] r, j, k);
        vec = '0;
        vec.unit = u;
        vec.vl = n;
        vec.res = r;
        vec.opj = j;
        vec.opk = k;
    endfunction
    function automatic vsb_req_t sc();
        sc = '0;
        sc.kind = VSB_K_SCALAR;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // request held from this edge until the edge that takes it
    task automatic put(input vsb_req_t w, output int t);
        int n;
        n = 0;
        rq <= w;
        valid <= 1'b1;
        @(negedge i_clk);
        while (o_issue !== 1'b1 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 400) begin
            n_fail++;
        end
        t = cyc;
        @(posedge i_clk);
    endtask
    task automatic idle();
        valid <= 1'b0;
        repeat (24) @(posedge i_clk);
    endtask
    task automatic conclude();
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic s_chain();
        int t0, t1, t2, t3;
        put(vec(VSB_U_LOGIC, 7'h08, 4'h9, 4'hA, 4'hB), t0);
        put(vec(VSB_U_FADD, 7'h08, 4'hC, 4'h9, 4'h0), t1);
        put(vec(VSB_U_SHIFT, 7'h08, 4'hA, 4'h0, 4'h0), t2);
        put(vec(VSB_U_LOGIC, 7'h08, 4'hD, 4'hE, 4'h0), t3);
        idle();
        chk(t1, t0 + 4);
        chk(t2, t0 + 10);
        chk(t3, t0 + 11);
    endtask
    task automatic s_short();
        int t0, t1, t2;
        put(vec(VSB_U_FMUL, 7'h03, 4'hA, 4'hC, 4'hD), t0);
        put(vec(VSB_U_LOGIC, 7'h03, 4'hC, 4'h0, 4'h0), t1);
        put(vec(VSB_U_LOGIC, 7'h03, 4'hA, 4'h0, 4'h0), t2);
        idle();
        chk(t1, t0 + 7);
        chk(t2, t0 + 15);
    endtask
    task automatic s_mem();
        vsb_req_t b;
        int t0, t1, t2, t3, t4, t5, t6;
        put(vec(VSB_U_MEM, 7'h02, 4'hB, 4'h0, 4'h0), t0);
        b = sc();
        b.kind = VSB_K_BLKCOPY;
        b.blk_load = 1'b1;
        b.cnt = 6'h03;
        put(b, t1);
        put(sc(), t2);
        b.blk_load = 1'b0;
        b.cnt = 6'h02;
        put(b, t3);
        put(sc(), t4);
        b = vec(VSB_U_MEM, 7'h04, 4'h0, 4'hE, 4'h0);
        b.vstore = 1'b1;
        put(b, t5);
        put(vec(VSB_U_LOGIC, 7'h04, 4'hE, 4'h0, 4'h0), t6);
        idle();
        chk(t1, t0 + 7);
        chk(t2, t1 + 17);
        chk(t4, t3 + 8);
        chk(t6, t5 + 10);
    endtask
    task automatic s_share();
        vsb_req_t s;
        int t0, t1;
        put(vec(VSB_U_FADD, 7'h04, 4'h9, 4'hA, 4'h0), t0);
        s = sc();
        s.unit = VSB_U_FADD;
        s.unit_en = 1'b1;
        put(s, t1);
        idle();
        chk(t1, t0 + 9);
    endtask
    task automatic s_branch();
        vsb_req_t b;
        int t0, t1, t2, c0;
        int gap [3] = '{2, 5, 13};
        sel <= 1'b0;
        len <= 8'h03;
        ld <= 1'b1;
        @(negedge i_clk);
        c0 = cyc;
        @(posedge i_clk);
        ld <= 1'b0;
        b = sc();
        b.kind = VSB_K_BRANCH;
        put(b, t0);
        chk(t0, c0 + 5);
        b.uses_s = 1'b1;
        for (int i = 0; i < 3; i++) begin
            b.br = vsb_br_t'(i);
            put(b, t1);
            put(sc(), t2);
            chk(t2, t1 + gap[i]);
        end
        b = sc();
        b.pair = 1'b1;
        put(b, t1);
        put(sc(), t2);
        idle();
        chk(t2, t1 + 2);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        valid = 1'b0;
        rq = '0;
        ld = 1'b0;
        sel = 1'b0;
        len = 8'h00;
        cyc = 0;
        n_fail = 0;
        checks = 0;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        chk({15'h0, ubusy, vbusy, mem_quiet, hold}, 32'h2);
        @(posedge i_clk);
        s_chain();
        s_short();
        s_mem();
        s_share();
        s_branch();
        conclude();
    end
    // whole run is a few hundred periods
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        conclude();
    end
endmodule
